// [rtl/sensor_i2c_target_port.sv]
// two-wire target port: addressing, register pointer, byte read and write
`include "sensor_i2c_regs.svh"

module sensor_i2c_target_port #(
    parameter int WDOG_CYCLES = `WDOG_CYCLES,
    parameter int WDOG_W = `WDOG_WIDTH
) (
    // clock, reset and enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // bus lines, data is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic data_out_strap_pin,
    input wire logic chip_select_strap_pin,
    // register file side
    output sensor_i2c_pkg::reg_wr_t reg_wr,
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data,
    // status
    output logic bus_busy,
    output logic port_reset
);
    import sensor_i2c_pkg::*;

    port_regs_t s;
    port_regs_t next_s;
    bus_evt_t evt;
    logic wdog_fire;
    logic [6:0] own_addr;
    logic abort;

    // line decoder
    bus_line_events u_events (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .evt(evt)
    );

    // watchdog watches our own pull-down against clock activity
    bus_lockup_watchdog #(
        .WDOG_CYCLES(WDOG_CYCLES),
        .WDOG_W(WDOG_W),
        .WDOG_ENABLE(`WDOG_ENABLE)
    ) u_watchdog (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .held(s.sda_oe),
        .activity(evt.scl_rise | evt.scl_fall),
        .fire(wdog_fire)
    );

    // strapped address; five fixed bits, ten-bit headers never match
    assign own_addr = {`TGT_ADDR_HI, s.strap};
    assign abort = wdog_fire | evt.start | evt.stop;

    // next state
    always_comb begin
        next_s = s;
        next_s.wr.wr = 1'b0;
        next_s.lockup = wdog_fire;
        next_s.busy = evt.busy;
        next_s.sda_o = 1'b0;
        next_s.strap = {chip_select_strap_pin, data_out_strap_pin};
        if (wdog_fire) begin
            // port reset; the pointer survives, only the transfer dies
            next_s.st = ST_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.bit_cnt = `BIT_FIRST;
            next_s.byte_full = 1'b0;
        end else if (evt.start) begin
            // a repeated start reopens addressing from any phase
            next_s.st = ST_ADDR;
            next_s.sda_oe = 1'b0;
            next_s.bit_cnt = `BIT_FIRST;
            next_s.byte_full = 1'b0;
        end else if (evt.stop) begin
            next_s.st = ST_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.st)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    // shift in on the rising clock edge
                    if (evt.scl_rise && !s.byte_full) begin
                        next_s.shift = {s.shift[6:0], sda_in};
                        if (s.bit_cnt == `BIT_LAST) begin
                            next_s.byte_full = 1'b1;
                        end else begin
                            next_s.bit_cnt = s.bit_cnt + 3'h1;
                        end
                    end
                    // act on the fall after the eighth bit
                    if (evt.scl_fall && s.byte_full) begin
                        next_s.byte_full = 1'b0;
                        next_s.bit_cnt = `BIT_FIRST;
                        next_s.sda_oe = 1'b1;
                        if (s.st == ST_ADDR) begin
                            if (s.shift[7:1] == own_addr) begin
                                next_s.st = ST_ADDR_ACK;
                                next_s.rw = s.shift[0];
                                // reads restart at the written pointer
                                next_s.rd_ptr = s.reg_ptr;
                            end else begin
                                next_s.st = ST_IGNORE;
                                next_s.sda_oe = 1'b0;
                            end
                        end else if (s.st == ST_REG) begin
                            next_s.st = ST_REG_ACK;
                            next_s.reg_ptr = s.shift;
                            next_s.rd_ptr = s.shift;
                        end else begin
                            next_s.st = ST_WDATA_ACK;
                            next_s.wr.wr = 1'b1;
                            next_s.wr.addr = s.reg_ptr;
                            next_s.wr.data = s.shift;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (evt.scl_fall) begin
                        if (s.rw) begin
                            // first read byte, msb first
                            next_s.st = ST_RDATA;
                            next_s.shift = reg_rd_data;
                            next_s.sda_oe = ~reg_rd_data[7];
                        end else begin
                            next_s.st = ST_REG;
                            next_s.sda_oe = 1'b0;
                        end
                    end
                end
                ST_REG_ACK: begin
                    if (evt.scl_fall) begin
                        next_s.st = ST_WDATA;
                        next_s.sda_oe = 1'b0;
                    end
                end
                ST_WDATA_ACK: begin
                    // only one data byte per write; later bytes get no ack
                    if (evt.scl_fall) begin
                        next_s.st = ST_IGNORE;
                        next_s.sda_oe = 1'b0;
                    end
                end
                ST_RDATA: begin
                    // change data only while the clock is low
                    if (evt.scl_fall) begin
                        if (s.bit_cnt == `BIT_LAST) begin
                            next_s.st = ST_RACK;
                            next_s.sda_oe = 1'b0;
                            next_s.bit_cnt = `BIT_FIRST;
                            next_s.rd_ptr = s.rd_ptr + `PTR_STEP;
                        end else begin
                            next_s.bit_cnt = s.bit_cnt + 3'h1;
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = ~s.shift[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (evt.scl_rise) begin
                        next_s.cont = ~sda_in;
                    end
                    if (evt.scl_fall) begin
                        if (s.cont) begin
                            next_s.st = ST_RDATA;
                            next_s.shift = reg_rd_data;
                            next_s.sda_oe = ~reg_rd_data[7];
                        end else begin
                            next_s.st = ST_IGNORE;
                            next_s.sda_oe = 1'b0;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_s.sda_oe = 1'b0;
                end
                default: begin
                    next_s.st = ST_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // state register; clock enable freezes everything
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.bit_cnt <= `BIT_FIRST;
            s.shift <= `BYTE_ZERO;
            s.reg_ptr <= `REG_PTR_RST;
            s.rd_ptr <= `REG_PTR_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign sda_out = s.sda_o;
    assign sda_oe = s.sda_oe;
    assign reg_wr = s.wr;
    assign reg_rd_addr = s.rd_ptr;
    assign bus_busy = s.busy;
    assign port_reset = s.lockup;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n || !clk_en);

    a_addr_fixed_bits: assert property (
        $rose(s.st == ST_ADDR_ACK) |-> $past(s.shift[7:3]) == `TGT_ADDR_HI)
        else $error("acknowledged address with wrong fixed bits");

    a_addr_strap_bits: assert property (
        $rose(s.st == ST_ADDR_ACK) |-> $past(s.shift[2:1]) == $past(s.strap))
        else $error("acknowledged address ignoring straps");

    a_addr_foreign: assert property (
        (s.st == ST_ADDR && evt.scl_fall && s.byte_full && !abort
            && s.shift[7:1] != own_addr) |=> s.st == ST_IGNORE && !s.sda_oe)
        else $error("foreign address not ignored");

    a_ack_held: assert property (
        (s.st == ST_ADDR_ACK && !evt.scl_fall && !abort) |=> s.sda_oe)
        else $error("target acknowledge released early");

    a_write_strobe: assert property (
        s.wr.wr |-> $past(s.st) == ST_WDATA && s.wr.addr == s.reg_ptr)
        else $error("write strobe out of place");

    a_read_start_ptr: assert property (
        ($rose(s.st == ST_ADDR_ACK) && s.rw) |-> s.rd_ptr == s.reg_ptr)
        else $error("read does not start at written pointer");

    a_read_incr: assert property (
        $rose(s.st == ST_RACK) |-> s.rd_ptr == $past(s.rd_ptr) + `PTR_STEP)
        else $error("pointer not incremented after read byte");

    sequence sq_nack_bit;
        (s.st == ST_RACK && !s.cont && evt.scl_fall && !abort);
    endsequence

    a_nack_release: assert property (
        sq_nack_bit |=> s.st == ST_IGNORE ##1 !s.sda_oe)
        else $error("target kept sending after not-acknowledge");

    a_stop_idle: assert property (
        (evt.stop && !wdog_fire) |=> s.st == ST_IDLE && !s.sda_oe)
        else $error("stop did not end the transfer");

    a_wdog_reset: assert property (
        wdog_fire |=> s.st == ST_IDLE && !s.sda_oe && port_reset)
        else $error("watchdog did not reset the port");

    // read side: bit drive, ack slot and the controller's answer
    sequence sq_read_entry;
        (s.st == ST_ADDR_ACK && s.rw && evt.scl_fall && !abort);
    endsequence

    a_read_first_bit: assert property (
        sq_read_entry |=> s.st == ST_RDATA && s.sda_oe == !$past(reg_rd_data[7]))
        else $error("first read bit not driven");

    a_read_bit_shift: assert property (
        (s.st == ST_RDATA && evt.scl_fall && s.bit_cnt != `BIT_LAST && !abort)
            |=> s.sda_oe == !$past(s.shift[6]))
        else $error("read bit not shifted out");

    a_ack_slot_free: assert property (
        $rose(s.st == ST_RACK) |-> !s.sda_oe)
        else $error("data line held during controller acknowledge");

    a_rack_sample: assert property (
        (s.st == ST_RACK && evt.scl_rise && !abort) |=> s.cont == !$past(sda_in))
        else $error("controller acknowledge not sampled");

    // write side: pointer load and the single data byte
    a_reg_ptr_load: assert property (
        (s.st == ST_REG && evt.scl_fall && s.byte_full && !abort)
            |=> s.reg_ptr == $past(s.shift) && s.rd_ptr == s.reg_ptr)
        else $error("register byte not loaded into pointer");

    sequence sq_data_ack_end;
        (s.st == ST_WDATA_ACK && evt.scl_fall && !abort);
    endsequence

    a_one_data_byte: assert property (
        sq_data_ack_end |=> s.st == ST_IGNORE && !s.sda_oe)
        else $error("second write data byte accepted");

    // line side: busy status two cycles behind the start, silence after refusal
    a_busy_output: assert property (
        evt.start |=> ##1 bus_busy)
        else $error("bus busy status missing after start");

    a_ignore_quiet: assert property (
        s.st == ST_IGNORE |-> !s.sda_oe)
        else $error("data line driven while ignoring");

endmodule

// [rtl/sensor_i2c_regs.svh]
// address, reset and timing constants of the sensor two-wire target port
`ifndef SENSOR_I2C_REGS_SVH
`define SENSOR_I2C_REGS_SVH

`define TGT_ADDR_HI 5'h04
`define REG_PTR_RST 8'h00
`define BYTE_ZERO 8'h00
`define PTR_STEP 8'h01
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define WDOG_PERIOD_MS 50
`define CLK_FREQ_HZ 10000000
`define MS_PER_S 1000
`define WDOG_CYCLES ((`WDOG_PERIOD_MS * `CLK_FREQ_HZ) / `MS_PER_S)
`define WDOG_WIDTH 20
`define WDOG_ENABLE 1'h1

`endif

// [rtl/sensor_i2c_pkg.sv]
// shared types of the sensor two-wire target port
package sensor_i2c_pkg;

    // byte phases of one transaction
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_REG = 4'b0011,
        ST_REG_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000,
        ST_IGNORE = 4'b1001
    } port_state_t;

    // decoded line events, one cycle each except busy
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic busy;
    } bus_evt_t;

    // register write strobe towards the register file
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // whole state of the target port
    typedef struct packed {
        port_state_t st;
        logic [2:0] bit_cnt;
        logic byte_full;
        logic [7:0] shift;
        logic [7:0] reg_ptr;
        logic [7:0] rd_ptr;
        logic rw;
        logic cont;
        logic sda_o;
        logic sda_oe;
        logic [1:0] strap;
        logic busy;
        logic lockup;
        reg_wr_t wr;
    } port_regs_t;

endpackage

// [rtl/bus_line_events.sv]
// start, stop and clock edge decoder of the two-wire bus lines
module bus_line_events (
    // clock, reset and enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // bus lines, synchronous to ref_clk
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded events
    output sensor_i2c_pkg::bus_evt_t evt
);
    import sensor_i2c_pkg::*;

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        logic seen_fall;
        logic busy;
    } line_state_t;

    line_state_t s;
    line_state_t next_s;
    logic start_c;
    logic stop_c;
    logic fall_c;

    // edges against the previous sample
    always_comb begin
        fall_c = s.scl_q & ~scl_in;
        start_c = s.scl_q & scl_in & s.sda_q & ~sda_in;
        // a stop needs a clock fall since the start
        stop_c = s.scl_q & scl_in & ~s.sda_q & sda_in & s.seen_fall;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        next_s.seen_fall = ~start_c & (s.seen_fall | fall_c);
        next_s.busy = start_c | (s.busy & ~stop_c);
        evt.scl_rise = ~s.scl_q & scl_in;
        evt.scl_fall = fall_c;
        evt.start = start_c;
        evt.stop = stop_c;
        evt.busy = s.busy;
    end

    // idle bus reads high on both lines
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{1'b1, 1'b1, 1'b1, 1'b0};
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // start, clock kept high, then data rises: the glitch a controller must avoid
    sequence sq_start_then_rise;
        start_c ##1 (s.scl_q && scl_in)[*3] ##1 (s.scl_q && scl_in && !s.sda_q && sda_in);
    endsequence

    a_start_stop_glitch: assert property (@(posedge ref_clk)
        disable iff (!arst_n || !clk_en) sq_start_then_rise |-> !stop_c)
        else $error("stop right after start was recognised");

    a_start_sets_busy: assert property (@(posedge ref_clk)
        disable iff (!arst_n || !clk_en) start_c |=> evt.busy)
        else $error("bus not busy after start");

endmodule

// [rtl/bus_lockup_watchdog.sv]
// lock-up watchdog: fires when the port holds the data line too long
`include "sensor_i2c_regs.svh"

module bus_lockup_watchdog #(
    parameter int WDOG_CYCLES = `WDOG_CYCLES,
    parameter int WDOG_W = `WDOG_WIDTH,
    parameter logic WDOG_ENABLE = `WDOG_ENABLE
) (
    // clock, reset and enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // observed port signals
    input wire logic held,
    input wire logic activity,
    // one-cycle port reset request
    output logic fire
);
    import sensor_i2c_pkg::*;

    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYCLES - 1);

    typedef struct packed {
        logic [WDOG_W-1:0] cnt;
        logic fire;
    } wdog_state_t;

    wdog_state_t s;
    wdog_state_t next_s;

    // any clock edge proves the bus alive, so only a stuck line counts
    always_comb begin
        next_s = s;
        next_s.fire = 1'b0;
        if (!WDOG_ENABLE || !held || activity) begin
            next_s.cnt = '0;
        end else if (s.cnt == WDOG_LAST) begin
            next_s.cnt = '0;
            next_s.fire = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign fire = s.fire;

    a_wdog_expiry: assert property (@(posedge ref_clk)
        disable iff (!arst_n || !clk_en) s.fire |-> $past(s.cnt) == WDOG_LAST)
        else $error("watchdog fired before its period");

    a_wdog_activity: assert property (@(posedge ref_clk)
        disable iff (!arst_n || !clk_en) activity |=> !s.fire && s.cnt == '0)
        else $error("watchdog kept counting across bus activity");

endmodule

// [dv/bus_controller_model.sv]
// bus controller model that drives the far side of the two-wire port
module bus_controller_model (
    // clock
    input wire logic ref_clk,
    // bus lines, data is open drain with pull-up
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idle: clock high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // every change lands on the falling edge, away from the port's sampling
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // start or repeated start, from clock high or low
    task automatic start();
        sda_pull = 1'b0;
        idle(2);
        scl = 1'b1;
        idle(4);
        sda_pull = 1'b1;
        idle(4);
        scl = 1'b0;
        idle(2);
    endtask

    // stop, entered with clock low
    task automatic stop();
        sda_pull = 1'b1;
        idle(2);
        scl = 1'b1;
        idle(4);
        sda_pull = 1'b0;
        idle(4);
    endtask

    // start then stop with no clock fall, only when a test asks for it
    task automatic glitch();
        sda_pull = 1'b1;
        idle(4);
        sda_pull = 1'b0;
        idle(4);
    endtask

    // one bit: data set while clock low, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull = ~b;
        idle(2);
        scl = 1'b1;
        idle(2);
        r = sda_line;
        idle(2);
        scl = 1'b0;
        idle(2);
    endtask

    // byte out msb first, then the target's acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask

    // byte in, then our acknowledge or not-acknowledge
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(nack, r);
    endtask
endmodule

// [dv/tb_sensor_i2c_target_port.sv]
// self-checking bench of the two-wire target port
module tb_sensor_i2c_target_port;
    timeunit 1ns;
    timeprecision 1ns;

    // short watchdog keeps the lock-up run brief
    localparam int WDOG_SIM = 64;
    localparam logic [7:0] KEY = 8'h3c;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic do_strap = 1'b0;
    logic cs_strap = 1'b0;
    logic scl;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic sda_line;
    sensor_i2c_pkg::reg_wr_t reg_wr;
    logic [7:0] reg_rd_addr;
    logic [7:0] reg_rd_data;
    logic bus_busy;
    logic port_reset;
    int errors = 0;
    int comparisons = 0;
    int wr_count = 0;
    logic [15:0] wr_last = 16'h0000;

    always #50 ref_clk = ~ref_clk;

    // wired-and data line with pull-up; register file is a keyed lookup
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
    assign reg_rd_data = reg_rd_addr ^ KEY;

    // count write strobes at the falling edge, where they have settled
    always @(negedge ref_clk) begin
        if (reg_wr.wr === 1'b1) begin
            wr_count <= wr_count + 1;
            wr_last <= {reg_wr.addr, reg_wr.data};
        end
    end

    sensor_i2c_target_port #(.WDOG_CYCLES(WDOG_SIM), .WDOG_W(20)) u_dut (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(1'b1),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .data_out_strap_pin(do_strap),
        .chip_select_strap_pin(cs_strap),
        .reg_wr(reg_wr),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data),
        .bus_busy(bus_busy),
        .port_reset(port_reset)
    );

    bus_controller_model u_ctl (
        .ref_clk(ref_clk),
        .sda_line(sda_line),
        .scl(scl),
        .sda_pull(sda_pull)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("counts: %0d compared, %0d mismatched", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic addr_phase(input logic [6:0] a, input logic rw, output logic ack);
        u_ctl.start();
        u_ctl.send_byte({a, rw}, ack);
    endtask

    // address with write, then the register byte
    task automatic write_phase(input logic [7:0] ra);
        logic ack;
        addr_phase(7'h10, 1'b0, ack);
        check("wr addr ack", ack, 8'h00);
        u_ctl.send_byte(ra, ack);
        check("reg ack", ack, 8'h00);
    endtask

    task automatic t_reset();
        check("oe", sda_oe, 8'h00);
        check("drive", sda_out, 8'h00);
        check("ptr", reg_rd_addr, 8'h00);
        check("busy", bus_busy, 8'h00);
        check("rst", port_reset, 8'h00);
        $display("done: reset");
    endtask

    // every strap setting against matching, foreign and ten-bit addresses
    task automatic t_addr();
        logic [6:0] cand [6] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h30, 7'h78};
        logic ack;
        for (int s = 0; s < 4; s++) begin
            {cs_strap, do_strap} = s[1:0];
            for (int c = 0; c < 6; c++) begin
                addr_phase(cand[c], 1'b0, ack);
                check("addr ack", ack, (cand[c] == 7'(16 + s)) ? 8'h00 : 8'h01);
                check("busy", bus_busy, 8'h01);
                u_ctl.stop();
                check("free", bus_busy, 8'h00);
            end
        end
        {cs_strap, do_strap} = 2'h0;
        $display("done: addr");
    endtask

    // read n bytes from the current start address, last one not acknowledged
    task automatic t_read(input logic [7:0] first, input int n);
        logic ack;
        logic [7:0] d;
        addr_phase(7'h10, 1'b1, ack);
        check("rd addr ack", ack, 8'h00);
        for (int i = 0; i < n; i++) begin
            u_ctl.recv_byte(i == n - 1, d);
            check("rd data", d, (first + 8'(i)) ^ KEY);
        end
        check("released", sda_line, 8'h01);
        check("ptr", reg_rd_addr, first + 8'(n));
        u_ctl.stop();
        $display("done: read");
    endtask

    // one data byte acked and strobed, a second refused
    task automatic t_write();
        int c0;
        logic ack;
        write_phase(8'hfe);
        c0 = wr_count;
        u_ctl.send_byte(8'h5a, ack);
        check("data ack", ack, 8'h00);
        u_ctl.send_byte(8'h77, ack);
        check("extra ack", ack, 8'h01);
        u_ctl.stop();
        check("wr count", 8'(wr_count - c0), 8'h01);
        check("wr addr", wr_last[15:8], 8'hfe);
        check("wr data", wr_last[7:0], 8'h5a);
        $display("done: write");
    endtask

    // stop straight after start is not seen; a new start recovers
    task automatic t_glitch();
        logic ack;
        u_ctl.glitch();
        check("busy held", bus_busy, 8'h01);
        addr_phase(7'h10, 1'b0, ack);
        check("after glitch", ack, 8'h00);
        u_ctl.stop();
        check("free", bus_busy, 8'h00);
        $display("done: glitch");
    endtask

    // clock held low while the port pulls data low until the watchdog fires
    task automatic t_wdog();
        logic r;
        int n;
        u_ctl.start();
        // address 0x10 with write: only bit 5 of the byte is high
        for (int i = 7; i >= 0; i--) begin
            u_ctl.bit_xfer(i == 5, r);
        end
        check("ack held", sda_oe, 8'h01);
        n = 0;
        while (port_reset !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            errors++;
            $display("[ERR] wdog expected fire seen none");
            stop_test();
        end
        check("wdog late", 8'(n > WDOG_SIM - 8), 8'h01);
        @(negedge ref_clk);
        check("wdog oe", sda_oe, 8'h00);
        u_ctl.stop();
        write_phase(8'h10);
        u_ctl.stop();
        $display("done: wdog");
    endtask

    // release reset with the bus idle, run every scenario, then report
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        u_ctl.idle(4);
        t_reset();
        t_addr();
        t_read(8'h00, 2);
        t_write();
        write_phase(8'hfe);
        t_read(8'hfe, 3);
        t_read(8'hfe, 2);
        t_glitch();
        t_wdog();
        stop_test();
    end
endmodule
